// ===== rtl/bbc_pkg.sv
/*
  constants for the backlight brightness control block: command codes,
  addresses, control bit positions, reset values.
  assumes the command decoder outside hands over decoded command strobes.
*/
package bbc_pkg;
  // ----------------------------------------
  // command codes and addresses
  // ----------------------------------------
  localparam logic [7:0]  BBC_CODE_BRI_WR  = 8'h51;
  localparam logic [7:0]  BBC_CODE_BRI_RD  = 8'h52;
  localparam logic [7:0]  BBC_CODE_CTL_WR  = 8'h53;
  localparam logic [7:0]  BBC_CODE_CTL_RD  = 8'h54;
  localparam logic [15:0] BBC_ADDR_BRI_WR  = 16'h5100;
  localparam logic [15:0] BBC_ADDR_BRI_RD  = 16'h5200;
  localparam logic [15:0] BBC_ADDR_CTL_WR  = 16'h5300;
  localparam logic [15:0] BBC_ADDR_CTL_RD  = 16'h5400;
  localparam logic [7:0]  BBC_HIGH_BYTE    = 8'h00;
  // ----------------------------------------
  // control byte layout
  // ----------------------------------------
  localparam int BBC_BIT_BLOCK   = 5;
  localparam int BBC_BIT_AMBIENT = 4;
  localparam int BBC_BIT_DIM     = 3;
  localparam int BBC_BIT_BL      = 2;
  localparam int BBC_BIT_AUTO_BR = 1;
  localparam int BBC_BIT_AUTO_G  = 0;
  localparam logic [7:0] BBC_CTL_MASK = 8'h3f;
  // ----------------------------------------
  // reset values and timing
  // ----------------------------------------
  localparam logic [7:0] BBC_BRI_RST = 8'h00;
  localparam logic [7:0] BBC_CTL_RST = 8'h00;
  // one ramp step every this many ns
  localparam int BBC_RAMP_STEP_NS = 1000;
  localparam int BBC_CLK_NS       = 100;
  localparam int BBC_RAMP_CYC     = BBC_RAMP_STEP_NS / BBC_CLK_NS;
endpackage

// ===== rtl/bbc_pwm.sv
/*
  free running 8-bit pwm: duty code n gives (n+1)/256 high time, zero
  gives none. assumes a single clock and synchronous active low reset.
*/
`timescale 1ns/1ps
module bbc_pwm (
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  input  wire logic [7:0] duty,
  output logic            pwm_on
);
  typedef struct packed {
    logic [7:0] cnt;
    logic       on;
  } bbc_pwm_st_t;
  bbc_pwm_st_t s_r, s_nxt;

  always_comb begin
    s_nxt     = s_r;
    s_nxt.cnt = s_r.cnt + 8'h01;
    // linear map, code 0 dark, else high while cnt <= n
    s_nxt.on  = (duty != 8'h00) && (s_r.cnt <= duty);
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign pwm_on = s_r.on;

  property p_pwm_zero;
    @(posedge clk_sys) disable iff (!resetn)
      (duty == 8'h00) |=> !pwm_on;
  endproperty
  a_pwm_zero: assert property (p_pwm_zero) else $error("pwm on at zero");
  property p_pwm_full;
    @(posedge clk_sys) disable iff (!resetn)
      (duty == 8'hff) |=> pwm_on;
  endproperty
  a_pwm_full: assert property (p_pwm_full) else $error("pwm off at full");
endmodule

// ===== rtl/bbc_top.sv
/*
  brightness and backlight control register bank with pwm and enable pins.
  assumes the host command decoder gives one-cycle write and read strobes
  with the command code (serial link) or 16-bit address (other ports).
*/
`timescale 1ns/1ps
module bbc_top #(
  parameter int RAMP_CYC = bbc_pkg::BBC_RAMP_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic        cmd_valid,
  input  wire logic        cmd_serial,
  input  wire logic [15:0] cmd_addr,
  input  wire logic [15:0] cmd_wdata,
  input  wire logic [7:0]  light_adaptive_block,
  input  wire logic [7:0]  profile_brightness,
  input  wire logic        pwm_polarity_sel,
  input  wire logic        enable_pin_polarity_sel,
  output logic             rd_valid,
  output logic [15:0]      rd_data,
  output logic             backlight_pwm_pin,
  output logic             backlight_enable_pin,
  output logic [7:0]       brightness_level_eff,
  output logic [7:0]       aux_brightness_level,
  output logic             gamma_from_profile
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [7:0]  bri;
    logic [7:0]  ctl;
    logic [7:0]  ramp;
    logic [15:0] tick;
    logic        rdv;
    logic [15:0] rdd;
    logic [7:0]  eff;
    logic [7:0]  aux;
    logic        pwm;
    logic        en;
    logic        gam;
  } bbc_st_t;
  bbc_st_t s_r, s_nxt;

  logic        pwm_raw;
  logic [7:0]  duty;
  logic [7:0]  src;
  logic [7:0]  target;
  logic        is_bri_wr, is_bri_rd, is_ctl_wr, is_ctl_rd;
  logic        blk, amb, dim, bl, abr, agm;

  // ----------------------------------------
  // command decode
  // ----------------------------------------
  // serial link carries the code in the low byte, others the full address
  function automatic logic hit(input logic [15:0] a, input logic ser,
                               input logic [7:0] code,
                               input logic [15:0] addr);
    hit = ser ? (a[7:0] == code) : (a == addr);
  endfunction

  always_comb begin
    is_bri_wr = cmd_valid && hit(cmd_addr, cmd_serial,
      bbc_pkg::BBC_CODE_BRI_WR, bbc_pkg::BBC_ADDR_BRI_WR);
    is_bri_rd = cmd_valid && hit(cmd_addr, cmd_serial,
      bbc_pkg::BBC_CODE_BRI_RD, bbc_pkg::BBC_ADDR_BRI_RD);
    is_ctl_wr = cmd_valid && hit(cmd_addr, cmd_serial,
      bbc_pkg::BBC_CODE_CTL_WR, bbc_pkg::BBC_ADDR_CTL_WR);
    is_ctl_rd = cmd_valid && hit(cmd_addr, cmd_serial,
      bbc_pkg::BBC_CODE_CTL_RD, bbc_pkg::BBC_ADDR_CTL_RD);
  end

  assign blk = s_r.ctl[bbc_pkg::BBC_BIT_BLOCK];
  assign amb = s_r.ctl[bbc_pkg::BBC_BIT_AMBIENT];
  assign dim = s_r.ctl[bbc_pkg::BBC_BIT_DIM];
  assign bl  = s_r.ctl[bbc_pkg::BBC_BIT_BL];
  assign abr = s_r.ctl[bbc_pkg::BBC_BIT_AUTO_BR];
  assign agm = s_r.ctl[bbc_pkg::BBC_BIT_AUTO_G];

  // ----------------------------------------
  // brightness source and ramp target
  // ----------------------------------------
  always_comb begin
    // manual register or active profile
    src = abr ? profile_brightness : s_r.bri;
    // ambient block overrides the written level
    if (amb) begin
      src = light_adaptive_block;
    end
    target = blk ? src : 8'h00;
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    s_nxt     = s_r;
    s_nxt.rdv = 1'b0;
    if (is_bri_wr) begin
      s_nxt.bri = cmd_wdata[7:0];
    end
    if (is_ctl_wr) begin
      // bits 7:6 are held at zero
      s_nxt.ctl = cmd_wdata[7:0] & bbc_pkg::BBC_CTL_MASK;
    end
    if (is_bri_rd) begin
      s_nxt.rdv = 1'b1;
      s_nxt.rdd = {bbc_pkg::BBC_HIGH_BYTE, s_r.bri};
    end else if (is_ctl_rd) begin
      s_nxt.rdv = 1'b1;
      s_nxt.rdd = {bbc_pkg::BBC_HIGH_BYTE, s_r.ctl};
    end
    // ramp: with dim set any target change walks, otherwise steps; bl off clears at once
    s_nxt.tick = (s_r.tick == 16'(RAMP_CYC - 1)) ? 16'h0000
                 : s_r.tick + 16'h0001;
    if (!bl) begin
      s_nxt.ramp = 8'h00;
    end else if (!dim) begin
      s_nxt.ramp = target;
    end else if (s_r.tick == 16'h0000) begin
      // one code per step, a full sweep takes 255 steps
      if (s_r.ramp < target) begin
        s_nxt.ramp = s_r.ramp + 8'h01;
      end else if (s_r.ramp > target) begin
        s_nxt.ramp = s_r.ramp - 8'h01;
      end
    end
    s_nxt.eff = s_nxt.ramp;
    s_nxt.aux = blk ? light_adaptive_block : 8'h00;
    s_nxt.gam = agm;
    s_nxt.en  = bl ^ enable_pin_polarity_sel;
    // inactive pwm level follows polarity
    s_nxt.pwm = (blk && pwm_raw) ^ pwm_polarity_sel;
  end

  assign duty = s_r.ramp;

  bbc_pwm i_bbc_pwm (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .duty    (duty),
    .pwm_on  (pwm_raw)
  );

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rd_valid             = s_r.rdv;
  assign rd_data              = s_r.rdd;
  assign backlight_pwm_pin    = s_r.pwm;
  assign backlight_enable_pin = s_r.en;
  assign brightness_level_eff = s_r.eff;
  assign aux_brightness_level = s_r.aux;
  assign gamma_from_profile   = s_r.gam;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_bri_rd;
    @(posedge clk_sys) disable iff (!resetn)
      is_bri_rd |=> rd_valid && rd_data[7:0] == $past(s_r.bri);
  endproperty
  a_bri_rd: assert property (p_bri_rd) else $error("bad bri read");
  property p_ctl_rd;
    @(posedge clk_sys) disable iff (!resetn)
      (is_ctl_rd && !is_bri_rd) |=> rd_valid
        && rd_data == {bbc_pkg::BBC_HIGH_BYTE, $past(s_r.ctl)};
  endproperty
  a_ctl_rd: assert property (p_ctl_rd) else $error("bad ctl read");
  property p_ctl_wr;
    @(posedge clk_sys) disable iff (!resetn)
      is_ctl_wr |=> s_r.ctl ==
        ($past(cmd_wdata[7:0]) & bbc_pkg::BBC_CTL_MASK);
  endproperty
  a_ctl_wr: assert property (p_ctl_wr) else $error("ctl top bits set");
  property p_bri_wr;
    @(posedge clk_sys) disable iff (!resetn)
      is_bri_wr |=> s_r.bri == $past(cmd_wdata[7:0]);
  endproperty
  a_bri_wr: assert property (p_bri_wr) else $error("bri not stored");
  property p_rd_quiet;
    @(posedge clk_sys) disable iff (!resetn)
      !(is_bri_rd || is_ctl_rd) |=> !rd_valid;
  endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("stray rd");
  property p_blk_off;
    @(posedge clk_sys) disable iff (!resetn)
      (!blk && !dim) [*2] |=> brightness_level_eff == 8'h00
        && aux_brightness_level == 8'h00
        && backlight_pwm_pin == $past(pwm_polarity_sel);
  endproperty
  a_blk_off: assert property (p_blk_off) else $error("block off leak");
  property p_bl_off;
    @(posedge clk_sys) disable iff (!resetn)
      !bl |=> brightness_level_eff == 8'h00;
  endproperty
  a_bl_off: assert property (p_bl_off) else $error("bl off slow");
  property p_en_pin;
    @(posedge clk_sys) disable iff (!resetn)
      1'b1 |=> backlight_enable_pin == $past(bl ^ enable_pin_polarity_sel);
  endproperty
  a_en_pin: assert property (p_en_pin) else $error("enable pin");
  property p_ramp_step;
    @(posedge clk_sys) disable iff (!resetn)
      (bl && dim) |=> (s_r.ramp - $past(s_r.ramp) <= 8'h01)
        || ($past(s_r.ramp) - s_r.ramp <= 8'h01);
  endproperty
  a_ramp_step: assert property (p_ramp_step) else $error("ramp jump");
  property p_amb;
    @(posedge clk_sys) disable iff (!resetn)
      (bl && !dim && blk && amb) |=> s_r.ramp == $past(light_adaptive_block);
  endproperty
  a_amb: assert property (p_amb) else $error("ambient source");
  property p_gam;
    @(posedge clk_sys) disable iff (!resetn)
      1'b1 |=> gamma_from_profile == $past(agm);
  endproperty
  a_gam: assert property (p_gam) else $error("gamma select");
endmodule

// ===== testbench/bbc_host.sv
/*
  host model: issues one command per call.
  assumes bbc_top samples commands on the rising edge.
*/
`timescale 1ns/1ps
module bbc_host (
  input  wire logic   clk_sys,
  output logic        cmd_valid,
  output logic        cmd_serial,
  output logic [15:0] cmd_addr,
  output logic [15:0] cmd_wdata
);
  initial begin
    cmd_valid  = 1'b0;
    cmd_serial = 1'b0;
    cmd_addr   = 16'h0000;
    cmd_wdata  = 16'h0000;
  end
  task automatic send(input logic ser, input logic [7:0] code,
                      input logic [7:0] val);
    @(negedge clk_sys);
    cmd_valid  = 1'b1;
    cmd_serial = ser;
    cmd_addr   = ser ? {8'h00, code} : {code, 8'h00};
    cmd_wdata  = {8'h00, val};
    @(negedge clk_sys);
    cmd_valid  = 1'b0;
    // idle bus must not show the last value
    cmd_addr   = ~cmd_addr;
    cmd_wdata  = ~cmd_wdata;
  endtask
endmodule

// ===== testbench/bbc_top_bench.sv
/*
  self-checking bench for bbc_top.
  assumes bbc_host drives the command port.
*/
`timescale 1ns/1ps
module bbc_top_bench;
  logic        clk_sys = 1'b0;
  logic        resetn, cmd_valid, cmd_serial, pwm_pol, en_pol;
  logic [15:0] cmd_addr, cmd_wdata, rd_data;
  logic [7:0]  light, profile, eff, aux, bri, c, e;
  logic        rd_valid, pwm_pin, en_pin, gam;
  logic [15:0] exp_q[$];
  logic [7:0]  tbl[8] = '{8'h24, 8'h34, 8'h26, 8'h25,
                          8'h20, 8'h04, 8'h16, 8'h27};
  int          fail_count = 0;
  int          check_count = 0;
  int          n;
  always #50 clk_sys = ~clk_sys;
  bbc_host i_bbc_host (.clk_sys(clk_sys), .cmd_valid(cmd_valid),
    .cmd_serial(cmd_serial), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata));
  bbc_top #(.RAMP_CYC(1)) i_bbc_top (.clk_sys(clk_sys), .resetn(resetn),
    .cmd_valid(cmd_valid), .cmd_serial(cmd_serial), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .light_adaptive_block(light),
    .profile_brightness(profile), .pwm_polarity_sel(pwm_pol),
    .enable_pin_polarity_sel(en_pol), .rd_valid(rd_valid),
    .rd_data(rd_data), .backlight_pwm_pin(pwm_pin),
    .backlight_enable_pin(en_pin), .brightness_level_eff(eff),
    .aux_brightness_level(aux), .gamma_from_profile(gam));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic bad(input string m);
    fail_count++;
    $display("mismatch at %0t: %s", $time, m);
  endtask
  task automatic check_rd(input logic [15:0] got);
    check_count++;
    if (exp_q.size() == 0) bad("unexpected read answer");
    else if (got !== exp_q.pop_front()) bad("read data");
  endtask
  task automatic check_lvl(input logic [7:0] got, input logic [7:0] x);
    check_count++;
    if (got !== x) bad("level");
  endtask
  task automatic check_bit(input logic got, input logic x);
    check_count++;
    if (got !== x) bad("flag");
  endtask
  task automatic rd(input logic s, input logic [7:0] k, input logic [7:0] x);
    exp_q.push_back({8'h00, x});
    i_bbc_host.send(s, k, x);
  endtask
  task automatic settle;
    repeat (3) @(negedge clk_sys);
  endtask
  // reads answered one cycle late, compared against the oldest note
  always @(negedge clk_sys) if (rd_valid === 1'b1) check_rd(rd_data);
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    resetn = 1'b0; pwm_pol = 1'b0; en_pol = 1'b0;
    light = 8'h00; profile = 8'h00;
    void'($urandom(70197));
    repeat (12) @(negedge clk_sys);
    resetn = 1'b1;
    check_lvl(eff, 8'h00);
    rd(1'b1, bbc_pkg::BBC_CODE_BRI_RD, 8'h00);
    rd(1'b0, bbc_pkg::BBC_CODE_CTL_RD, 8'h00);
    bri = 8'($urandom); light = 8'($urandom); profile = 8'($urandom);
    i_bbc_host.send(1'b0, bbc_pkg::BBC_CODE_BRI_WR, bri);
    rd(1'b1, bbc_pkg::BBC_CODE_BRI_RD, bri);
    i_bbc_host.send(1'b1, bbc_pkg::BBC_CODE_CTL_WR, 8'hff);
    rd(1'b0, bbc_pkg::BBC_CODE_CTL_RD, 8'h3f);
    i_bbc_host.send(1'b0, 8'h55, 8'h00); // unmapped, no answer
    i_bbc_host.send(1'b1, 8'h50, 8'h00);
    foreach (tbl[i]) begin
      c = tbl[i];
      en_pol = 1'($urandom);
      i_bbc_host.send(1'($urandom), bbc_pkg::BBC_CODE_CTL_WR, c);
      settle();
      e = (!c[5] || !c[2]) ? 8'h00 : c[4] ? light : c[1] ? profile : bri;
      check_lvl(eff, e);
      check_lvl(aux, c[5] ? light : 8'h00);
      check_bit(gam, c[0]);
      check_bit(en_pin, c[2] ^ en_pol);
    end
    i_bbc_host.send(1'b0, bbc_pkg::BBC_CODE_CTL_WR, 8'h04);
    pwm_pol = 1'b1;
    settle();
    check_bit(pwm_pin, 1'b1);
    check_lvl(eff, 8'h00);
    pwm_pol = 1'b0;
    i_bbc_host.send(1'b0, bbc_pkg::BBC_CODE_CTL_WR, 8'h24);
    settle();
    n = 0;
    repeat (256) @(negedge clk_sys) n += int'(pwm_pin === 1'b1);
    check_bit(n == ((bri == 8'h00) ? 0 : int'(bri) + 1), 1'b1);
    i_bbc_host.send(1'b1, bbc_pkg::BBC_CODE_BRI_WR, 8'hff);
    settle();
    n = 0;
    repeat (256) @(negedge clk_sys) n += int'(pwm_pin === 1'b1);
    check_bit(n == 256, 1'b1);
    // backlight off with dimming on drops the ramp to zero at once
    i_bbc_host.send(1'b0, bbc_pkg::BBC_CODE_CTL_WR, 8'h08);
    i_bbc_host.send(1'b1, bbc_pkg::BBC_CODE_BRI_WR, 8'h80);
    i_bbc_host.send(1'b0, bbc_pkg::BBC_CODE_CTL_WR, 8'h2c);
    settle();
    check_bit(eff > 8'h00 && eff < 8'h80, 1'b1);
    n = 0;
    while (eff !== 8'h80 && n < 400) begin
      @(negedge clk_sys);
      n++;
    end
    if (n >= 400) begin
      bad("ramp timeout");
    end
    i_bbc_host.send(1'b1, bbc_pkg::BBC_CODE_CTL_WR, 8'h28);
    settle();
    check_lvl(eff, 8'h00);
    settle();
    check_bit(exp_q.size() == 0, 1'b1);
    results();
  end
endmodule
